/* sialc_pkg.sv */
// Constants shared by the serial link control bit block
package sialc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] MODE_RESET = 32'h00000000;

  // Control register fields
  localparam int B_FAST_HDX = 16;
  localparam int B_AUTOSENSE = 15;
  localparam int B_POL_PLUS = 14;
  localparam int B_AUTOPOL = 13;
  localparam int B_LINK_TEST = 12;
  localparam int B_HBEAT = 11;
  localparam int B_COLL_DET = 10;
  localparam int B_COLL_SQ = 9;
  localparam int B_RX_SQ = 8;
  localparam int B_AUTONEG = 7;
  localparam int B_SLOW_HDX = 6;

  // Mode register fields
  localparam int B_PORT_AUI = 3;
  localparam int B_FULL_DUPLEX = 9;

  // Link code word layout
  localparam int LCW_FAST_HDX = 7;
  localparam int LCW_SLOW_FDX = 6;
  localparam int LCW_SLOW_HDX = 5;
  localparam logic [4:0] LCW_SELECTOR = 5'h01;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Heartbeat timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int HB_DELAY_NS = 800;
  localparam int HB_WIDTH_NS = 1000;
  localparam int HB_DELAY_CYC =
    (HB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HB_WIDTH_CYC =
    (HB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HB_CNT_W = 8;

endpackage

/* sialc_reg_if.sv */
// Register access carrier between bus slave and register bank
`timescale 1ns/1ps
`default_nettype none
interface sialc_reg_if;
  logic wr;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [7:0] raddr;
  logic [31:0] rdata;

  modport bus (output wr, output waddr, output wdata, output raddr,
    input rdata);
  modport regs (input wr, input waddr, input wdata, input raddr,
    output rdata);
endinterface
`default_nettype wire

/* sialc_ahb.sv */
// AHB-Lite slave front end for the register bank
`timescale 1ns/1ps
`default_nettype none
module sialc_ahb (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write flag
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  output logic [31:0] hrdata, // Read data
  sialc_reg_if.bus rb // Register access
);
  logic accept;
  logic wr_q;
  logic [7:0] waddr_q;
  logic rd_pend_q;
  logic [7:0] raddr_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic resp_q;

  assign accept = hsel & hready & htrans[1];

  // Write data phase follows the accepted address phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_q <= accept & hwrite & (hsize == sialc_pkg::HSIZE_WORD);
      if (accept) begin
        waddr_q <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so a just-written value is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_pend_q <= 1'b0;
      raddr_q <= 8'h00;
      ready_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      ready_q <= 1'b1;
      rdata_q <= rb.rdata;
    end else if (accept && !hwrite) begin
      rd_pend_q <= 1'b1;
      raddr_q <= haddr[7:0];
      ready_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= 1'b0;
    end
  end

  assign rb.wr = wr_q;
  assign rb.waddr = waddr_q;
  assign rb.wdata = hwdata;
  assign rb.raddr = raddr_q;
  assign hreadyout = ready_q;
  assign hrdata = rdata_q;
  assign hresp = resp_q;
endmodule
`default_nettype wire

/* sialc_hbeat.sv */
// Heartbeat generator imitating an external attachment unit
`timescale 1ns/1ps
`default_nettype none
module sialc_hbeat (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire logic enable, // Heartbeat generate enable
  input wire logic tx_done, // Transmit end pulse
  output logic pulse // Heartbeat output
);
  typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_PULSE} sialc_hb_t;
  localparam logic [7:0] DLY = 8'(sialc_pkg::HB_DELAY_CYC - 1);
  localparam logic [7:0] WID = 8'(sialc_pkg::HB_WIDTH_CYC - 1);

  sialc_hb_t state_q;
  logic [sialc_pkg::HB_CNT_W-1:0] cnt_q;
  logic pulse_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= HB_IDLE;
      cnt_q <= 8'h00;
      pulse_q <= 1'b0;
    end else begin
      unique case (state_q)
        HB_IDLE: begin
          if (enable && tx_done) begin
            state_q <= HB_WAIT;
            cnt_q <= DLY;
          end
        end
        HB_WAIT: begin
          if (cnt_q == 8'h00) begin
            state_q <= HB_PULSE;
            cnt_q <= WID;
            pulse_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        HB_PULSE: begin
          if (cnt_q == 8'h00) begin
            state_q <= HB_IDLE;
            pulse_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= HB_IDLE;
          pulse_q <= 1'b0;
        end
      endcase
    end
  end

  assign pulse = pulse_q;
endmodule
`default_nettype wire

/* sialc_top.sv */
// Serial link control bits: register bank and port control
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sialc_top (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write flag
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  output logic [31:0] hrdata, // AHB read data
  input wire logic tx_done, // Transmit packet end pulse
  input wire logic link_pulse_ok, // Link pulses seen
  input wire logic pol_reversed, // Autopolarity detector result
  input wire logic rx_data_in, // Raw receive data
  input wire logic tp_activity, // Twisted pair carrier seen
  input wire logic aui_activity, // AUI carrier seen
  output logic [15:0] link_code_word, // Transmitted code word
  output logic autoneg_run, // Autonegotiation active
  output logic mon_tp, // Twisted pair monitored
  output logic mon_aui, // AUI monitored
  output logic autopol_on, // Autopolarity logic enabled
  output logic rx_invert, // Receive polarity inverted
  output logic rx_data_out, // Polarity corrected data
  output logic link_test_on, // Link test logic running
  output logic link_pass, // Link test in pass state
  output logic heartbeat, // Heartbeat signal
  output logic hb_fail, // Descriptor heartbeat fail pulse
  output logic coll_det_on, // Collision detect enabled
  output logic aui_coll_rx_on, // AUI collision receivers on
  output logic tp_rx_on, // Twisted pair receiver on
  output logic aui_rx_on // AUI receiver on
);
  typedef enum logic {LT_FAIL, LT_PASS} sialc_lt_t;

  sialc_reg_if rb ();

  logic [31:0] ctrl_q;
  logic [31:0] mode_q;
  logic [31:0] stat_d;
  logic [31:0] rdata_d;

  logic aui_sel;
  logic tp_sel;
  logic autonegotiation_enable;
  logic apol_d;
  logic inv_d;

  logic [15:0] lcw_q;
  logic an_q;
  logic mon_tp_q;
  logic mon_aui_q;
  logic apol_q;
  logic inv_q;
  logic rxd_q;
  logic lte_q;
  sialc_lt_t lt_q;
  logic hbf_q;
  logic cld_q;
  logic csq_q;
  logic tprx_q;
  logic auirx_q;
  logic tp_seen_q;
  logic aui_seen_q;
  logic hb_pulse;

  sialc_ahb u_ahb (
    .clk(clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rb(rb.bus)
  );

  sialc_hbeat u_hbeat (
    .clk(clk),
    .reset(reset),
    .enable(ctrl_q[sialc_pkg::B_HBEAT]),
    .tx_done(tx_done),
    .pulse(hb_pulse)
  );

  // Control register, software written
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= sialc_pkg::CTRL_RESET;
    end else if (rb.wr && rb.waddr == sialc_pkg::OFS_CTRL) begin
      ctrl_q <= rb.wdata;
    end
  end

  // Port select and duplex mode register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_q <= sialc_pkg::MODE_RESET;
    end else if (rb.wr && rb.waddr == sialc_pkg::OFS_MODE) begin
      mode_q <= rb.wdata;
    end
  end

  assign aui_sel = mode_q[sialc_pkg::B_PORT_AUI];
  assign tp_sel = ~aui_sel;
  assign autonegotiation_enable = ctrl_q[sialc_pkg::B_AUTONEG];

  // Autopolarity only with link test also on
  assign apol_d = ctrl_q[sialc_pkg::B_AUTOPOL]
    & ctrl_q[sialc_pkg::B_LINK_TEST];

  // Polarity from detector, else from polarity plus
  always_comb begin
    inv_d = 1'b0;
    if (tp_sel) begin
      if (apol_d) begin
        inv_d = pol_reversed;
      end else begin
        inv_d = ~ctrl_q[sialc_pkg::B_POL_PLUS];
      end
    end
  end

  // Advertised abilities
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lcw_q <= 16'h0000;
    end else begin
      lcw_q <= 16'h0000;
      lcw_q[4:0] <= sialc_pkg::LCW_SELECTOR;
      lcw_q[sialc_pkg::LCW_FAST_HDX] <=
        autonegotiation_enable & ctrl_q[sialc_pkg::B_FAST_HDX];
      lcw_q[sialc_pkg::LCW_SLOW_FDX] <=
        mode_q[sialc_pkg::B_FULL_DUPLEX];
      lcw_q[sialc_pkg::LCW_SLOW_HDX] <=
        autonegotiation_enable & ctrl_q[sialc_pkg::B_SLOW_HDX];
    end
  end

  // Negotiation only when enabled and on twisted pair
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      an_q <= 1'b0;
    end else begin
      an_q <= autonegotiation_enable & tp_sel;
    end
  end

  // Port monitoring
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mon_tp_q <= 1'b0;
      mon_aui_q <= 1'b0;
    end else begin
      mon_tp_q <= ctrl_q[sialc_pkg::B_AUTOSENSE] | tp_sel;
      mon_aui_q <= ctrl_q[sialc_pkg::B_AUTOSENSE] | aui_sel;
    end
  end

  // Activity seen on monitored ports, cleared by a status read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tp_seen_q <= 1'b0;
      aui_seen_q <= 1'b0;
    end else begin
      if (tp_activity && mon_tp_q) begin
        tp_seen_q <= 1'b1;
      end else if (hreadyout == 1'b0 && rb.raddr == sialc_pkg::OFS_STAT) begin
        tp_seen_q <= 1'b0;
      end
      if (aui_activity && mon_aui_q) begin
        aui_seen_q <= 1'b1;
      end else if (hreadyout == 1'b0 && rb.raddr == sialc_pkg::OFS_STAT) begin
        aui_seen_q <= 1'b0;
      end
    end
  end

  // Receive polarity path
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      apol_q <= 1'b0;
      inv_q <= 1'b0;
      rxd_q <= 1'b0;
    end else begin
      apol_q <= apol_d & tp_sel;
      inv_q <= inv_d;
      rxd_q <= rx_data_in ^ inv_d;
    end
  end

  // Link test state, forced to pass when disabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lt_q <= LT_PASS;
      lte_q <= 1'b0;
    end else begin
      lte_q <= ctrl_q[sialc_pkg::B_LINK_TEST] & tp_sel;
      if (!ctrl_q[sialc_pkg::B_LINK_TEST] || aui_sel) begin
        lt_q <= LT_PASS;
      end else begin
        unique case (lt_q)
          LT_FAIL: begin
            if (link_pulse_ok) begin
              lt_q <= LT_PASS;
            end
          end
          LT_PASS: begin
            if (!link_pulse_ok) begin
              lt_q <= LT_FAIL;
            end
          end
        endcase
      end
    end
  end

  // Heartbeat fail reported per packet on twisted pair
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hbf_q <= 1'b0;
    end else begin
      hbf_q <= tx_done & tp_sel & ~ctrl_q[sialc_pkg::B_HBEAT];
    end
  end

  // Collision and receive squelch enables
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cld_q <= 1'b0;
      csq_q <= 1'b0;
      tprx_q <= 1'b0;
      auirx_q <= 1'b0;
    end else begin
      cld_q <= ctrl_q[sialc_pkg::B_COLL_DET];
      csq_q <= ctrl_q[sialc_pkg::B_COLL_SQ] & aui_sel;
      tprx_q <= ctrl_q[sialc_pkg::B_RX_SQ]
        & (tp_sel | ctrl_q[sialc_pkg::B_AUTOSENSE]);
      auirx_q <= ctrl_q[sialc_pkg::B_RX_SQ]
        & (aui_sel | ctrl_q[sialc_pkg::B_AUTOSENSE]);
    end
  end

  // Status word
  always_comb begin
    stat_d = 32'h00000000;
    stat_d[15:0] = lcw_q;
    stat_d[16] = lt_q == LT_PASS;
    stat_d[17] = an_q;
    stat_d[18] = mon_tp_q;
    stat_d[19] = mon_aui_q;
    stat_d[20] = inv_q;
    stat_d[21] = apol_q;
    stat_d[22] = tp_seen_q;
    stat_d[23] = aui_seen_q;
    stat_d[24] = lte_q;
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    unique case (rb.raddr)
      sialc_pkg::OFS_CTRL: rdata_d = ctrl_q;
      sialc_pkg::OFS_MODE: rdata_d = mode_q;
      sialc_pkg::OFS_STAT: rdata_d = stat_d;
      default: rdata_d = 32'h00000000;
    endcase
  end

  assign rb.rdata = rdata_d;

  assign link_code_word = lcw_q;
  assign autoneg_run = an_q;
  assign mon_tp = mon_tp_q;
  assign mon_aui = mon_aui_q;
  assign autopol_on = apol_q;
  assign rx_invert = inv_q;
  assign rx_data_out = rxd_q;
  assign link_test_on = lte_q;
  assign link_pass = lt_q == LT_PASS;
  assign heartbeat = hb_pulse;
  assign hb_fail = hbf_q;
  assign coll_det_on = cld_q;
  assign aui_coll_rx_on = csq_q;
  assign tp_rx_on = tprx_q;
  assign aui_rx_on = auirx_q;
endmodule
`default_nettype wire

/* sialc_asserts.sv */
// Port checker for the serial link control bits
`timescale 1ns/1ps
`default_nettype none
module sialc_asserts (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic tx_done, // Packet end
  input wire logic rx_data_in, // Raw data
  input wire logic [15:0] link_code_word, // Code word
  input wire logic autoneg_run, // Negotiating
  input wire logic mon_tp, // TP watched
  input wire logic mon_aui, // AUI watched
  input wire logic autopol_on, // Autopolarity
  input wire logic rx_invert, // Inversion
  input wire logic rx_data_out, // Data out
  input wire logic link_test_on, // Link test
  input wire logic link_pass, // Pass state
  input wire logic heartbeat, // Heartbeat
  input wire logic hb_fail, // Fail pulse
  input wire logic aui_coll_rx_on, // Coll rx
  input wire logic tp_rx_on, // TP rx
  input wire logic aui_rx_on // AUI rx
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] hb_len_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      hb_len_q <= 8'h00;
    else if (heartbeat)
      hb_len_q <= hb_len_q + 8'h01;
    else
      hb_len_q <= 8'h00;
  end
  sequence s_rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd_req |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait wrong");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("resp not okay");
  property p_lcw;
    !$past(reset) |-> link_code_word[4:0] == 5'h01 &&
      link_code_word[15:8] == 8'h00;
  endproperty
  a_lcw: assert property (p_lcw) else $error("code word frame");
  property p_neg_tp;
    autoneg_run |-> mon_tp;
  endproperty
  a_neg_tp: assert property (p_neg_tp) else $error("neg off tp");
  property p_coll_aui;
    aui_coll_rx_on |-> mon_aui;
  endproperty
  a_coll_aui: assert property (p_coll_aui) else $error("coll rx");
  property p_both_rx;
    tp_rx_on && aui_rx_on |-> mon_tp && mon_aui;
  endproperty
  a_both_rx: assert property (p_both_rx) else $error("both rx");
  property p_autopol;
    autopol_on |-> link_test_on;
  endproperty
  a_autopol: assert property (p_autopol) else $error("autopol");
  property p_pass;
    !link_test_on [*2] |-> link_pass;
  endproperty
  a_pass: assert property (p_pass) else $error("not pass");
  property p_polarity;
    !$past(reset) && $stable(rx_invert) |->
      rx_data_out == ($past(rx_data_in) ^ rx_invert);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity");
  property p_hb_len;
    $fell(heartbeat) |-> hb_len_q == 8'h7D;
  endproperty
  a_hb_len: assert property (p_hb_len) else $error("hb width");
  property p_hb_fail;
    hb_fail |-> $past(tx_done);
  endproperty
  a_hb_fail: assert property (p_hb_fail) else $error("hb fail");
endmodule
bind sialc_top sialc_asserts i_sialc_asserts (.clk(clk), .reset(reset),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .tx_done(tx_done),
  .rx_data_in(rx_data_in), .link_code_word(link_code_word),
  .autoneg_run(autoneg_run), .mon_tp(mon_tp), .mon_aui(mon_aui),
  .autopol_on(autopol_on), .rx_invert(rx_invert),
  .rx_data_out(rx_data_out), .link_test_on(link_test_on),
  .link_pass(link_pass), .heartbeat(heartbeat), .hb_fail(hb_fail),
  .aui_coll_rx_on(aui_coll_rx_on), .tp_rx_on(tp_rx_on),
  .aui_rx_on(aui_rx_on));
`default_nettype wire

/* sialc_medium.sv */
// Medium and link partner model
`timescale 1ns/1ps
`default_nettype none
module sialc_medium (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic send, // Finish a packet
  input wire logic link_ok, // Partner sends pulses
  input wire logic swapped, // Pair wired reversed
  output logic tx_done, // Packet end
  output logic link_pulse_ok, // Pulses seen
  output logic pol_reversed, // Reversal seen
  output logic rx_data_in, // Line data
  output logic tp_activity, // TP carrier
  output logic aui_activity // AUI carrier
);
  logic [3:0] lfsr_q;
  logic send_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr_q <= 4'h1;
      send_q <= 1'b0;
      tx_done <= 1'b0;
      link_pulse_ok <= 1'b1;
      pol_reversed <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
      send_q <= send;
      tx_done <= send & !send_q;
      link_pulse_ok <= link_ok;
      pol_reversed <= swapped;
    end
  end
  // Line data never rests on one level
  assign rx_data_in = lfsr_q[0];
  assign tp_activity = lfsr_q[1];
  assign aui_activity = lfsr_q[2];
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the serial link control bits
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  errors++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb;
  localparam logic [5:0] POL_TBL [5] = '{6'h28, 6'h0A, 6'h3F, 6'h19, 6'h02};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = sialc_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [15:0] link_code_word;
  logic send = 1'b0;
  logic link_ok = 1'b1;
  logic swapped = 1'b0;
  logic hreadyout, hresp, tx_done, link_pulse_ok, pol_reversed, rx_data_in;
  logic tp_activity, aui_activity, autoneg_run, mon_tp, mon_aui, autopol_on;
  logic rx_invert, rx_data_out, link_test_on, link_pass, heartbeat, hb_fail;
  logic coll_det_on, aui_coll_rx_on, tp_rx_on, aui_rx_on;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sialc_top i_sialc_top (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tx_done(tx_done),
    .link_pulse_ok(link_pulse_ok), .pol_reversed(pol_reversed),
    .rx_data_in(rx_data_in), .tp_activity(tp_activity),
    .aui_activity(aui_activity), .link_code_word(link_code_word),
    .autoneg_run(autoneg_run), .mon_tp(mon_tp), .mon_aui(mon_aui),
    .autopol_on(autopol_on), .rx_invert(rx_invert),
    .rx_data_out(rx_data_out), .link_test_on(link_test_on),
    .link_pass(link_pass), .heartbeat(heartbeat), .hb_fail(hb_fail),
    .coll_det_on(coll_det_on), .aui_coll_rx_on(aui_coll_rx_on),
    .tp_rx_on(tp_rx_on), .aui_rx_on(aui_rx_on));
  sialc_medium i_sialc_medium (.clk(clk), .reset(reset), .send(send),
    .link_ok(link_ok), .swapped(swapped), .tx_done(tx_done),
    .link_pulse_ok(link_pulse_ok), .pol_reversed(pol_reversed),
    .rx_data_in(rx_data_in), .tp_activity(tp_activity),
    .aui_activity(aui_activity));
  task automatic print_verdict;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset;
    logic [31:0] v;
    bus(1'b0, sialc_pkg::OFS_CTRL, 32'h0, v);
    `CHK("ctrl", sialc_pkg::CTRL_RESET, v)
    hsize <= 3'h0;
    wr(sialc_pkg::OFS_MODE, 32'hFFFFFFFF);
    hsize <= sialc_pkg::HSIZE_WORD;
    bus(1'b0, sialc_pkg::OFS_MODE, 32'h0, v);
    `CHK("mode", sialc_pkg::MODE_RESET, v)
    `CHK("lcw reset", 16'h00A1, link_code_word)
    wr(8'h0C, 32'h5A5A5A5A);
    bus(1'b0, 8'h0C, 32'h0, v);
    `CHK("unmapped", 32'h0, v)
  endtask
  task automatic t_advert;
    logic [31:0] c;
    logic [15:0] e;
    for (int i = 0; i < 16; i++) begin
      c = sialc_pkg::CTRL_RESET;
      c[16] = i[0];
      c[7] = i[1];
      c[6] = i[2];
      wr(sialc_pkg::OFS_MODE, {22'h0, i[3], 9'h0});
      wr(sialc_pkg::OFS_CTRL, c);
      e = {8'h0, i[0] & i[1], i[3], i[2] & i[1], 5'h01};
      `CHK("code word", e, link_code_word)
      `CHK("autoneg", i[1], autoneg_run)
    end
  endtask
  task automatic t_ports;
    logic [31:0] c;
    logic [31:0] v;
    logic t, a;
    for (int i = 0; i < 8; i++) begin
      c = sialc_pkg::CTRL_RESET;
      c[15] = i[0];
      c[10] = i[0];
      c[9] = !i[2];
      c[8] = i[2];
      t = i[0] | !i[1];
      a = i[0] | i[1];
      wr(sialc_pkg::OFS_MODE, {28'h0, i[1], 3'h0});
      wr(sialc_pkg::OFS_CTRL, c);
      `CHK("monitor", {t, a}, {mon_tp, mon_aui})
      `CHK("rx on", {t, a} & {2{i[2]}}, {tp_rx_on, aui_rx_on})
      `CHK("coll rx", i[1] & !i[2], aui_coll_rx_on)
      `CHK("coll det", i[0], coll_det_on)
      `CHK("neg aui", !i[1], autoneg_run)
      bus(1'b0, sialc_pkg::OFS_STAT, 32'h0, v);
      bus(1'b0, sialc_pkg::OFS_STAT, 32'h0, v);
      `CHK("stat mon", {a, t}, v[19:18])
      `CHK("stat seen", 2'h0, v[23:22] & ~{a, t})
    end
  endtask
  task automatic t_polarity;
    logic [31:0] c;
    logic [5:0] p;
    wr(sialc_pkg::OFS_MODE, 32'h0);
    for (int i = 0; i < 5; i++) begin
      p = POL_TBL[i];
      c = sialc_pkg::CTRL_RESET;
      c[14:12] = p[5:3];
      swapped <= p[2];
      wr(sialc_pkg::OFS_CTRL, c);
      `CHK("invert", p[1], rx_invert)
      `CHK("autopol", p[0], autopol_on)
    end
    swapped <= 1'b0;
  endtask
  task automatic t_link;
    int n;
    wr(sialc_pkg::OFS_CTRL, sialc_pkg::CTRL_RESET);
    link_ok <= 1'b0;
    for (n = 0; n < 50 && link_pass !== 1'b0; n++) @(posedge clk);
    `CHK("link fail", 2'h1, {link_pass, link_test_on})
    wr(sialc_pkg::OFS_CTRL, 32'hFFFFCFFF);
    `CHK("link forced", 2'h2, {link_pass, link_test_on})
    link_ok <= 1'b1;
  endtask
  task automatic pkt;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_heart;
    int n;
    int m;
    wr(sialc_pkg::OFS_CTRL, sialc_pkg::CTRL_RESET);
    pkt();
    `CHK("no fail", 1'b0, hb_fail)
    for (n = 1; n < 300 && heartbeat !== 1'b1; n++) @(posedge clk);
    `CHK("hb delay", 1'b1, n >= 100 && n <= 102)
    for (m = 0; m < 300 && heartbeat === 1'b1; m++) @(posedge clk);
    `CHK("hb width", sialc_pkg::HB_WIDTH_CYC, m)
    wr(sialc_pkg::OFS_CTRL, 32'hFFFFF7FF);
    pkt();
    `CHK("tp fail", 1'b1, hb_fail)
    wr(sialc_pkg::OFS_MODE, 32'h8);
    pkt();
    `CHK("aui fail", 1'b0, hb_fail)
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_advert();
    t_ports();
    t_polarity();
    t_link();
    t_heart();
    print_verdict();
  end
endmodule
`default_nettype wire
